//--- fan_ctrl_consts.svh
// Purpose: named constants for the dynamic fan threshold controller
// Assumes: included by the package and by each design module
// Notes: register positions are word indices; byte address is index times four
`ifndef FAN_CTRL_CONSTS_SVH
`define FAN_CTRL_CONSTS_SVH

`define NCH 3
`define PADDR_W 10

// register word indices
`define IDX_DUTY_BASE 8'h30
`define IDX_OPPT_BASE 8'h33
`define IDX_CTRL1 8'h36
`define IDX_CTRL2 8'h37
`define IDX_LIMIT_BASE 8'h4E
`define IDX_PWMCFG_BASE 8'h5C
`define IDX_ACOU1 8'h62
`define IDX_ACOU2 8'h63
`define IDX_START_BASE 8'h67
`define IDX_CONFIG 8'h7C

// control register 1 fields
`define C1_DYN_LSB 5
`define C1_CAP_LSB 2
`define C1_R2_CODE_LSB 0
// control register 2 fields
`define C2_R1_CODE_LSB 0
`define C2_LOC_CODE_LSB 3
`define C2_R2_CODE_LSB 6
// acoustic, pwm config and config register fields
`define AC1_EN1_BIT 3
`define AC1_RATE1_LSB 0
`define AC2_EN2_BIT 7
`define AC2_RATE2_LSB 4
`define AC2_EN3_BIT 3
`define AC2_RATE3_LSB 0
`define PWMCFG_SLOW_BIT 3
`define CONFIG_OFF64_BIT 0

// reset values
`define RST_CTRL 8'h00
`define RST_LIMIT_LO 8'h01
`define RST_LIMIT_HI 8'h7F
`define RST_OPPT 8'h46
`define RST_START 8'h5A
`define RST_ACOU 8'h00

// temperature arithmetic, 10-bit signed degrees
`define START_FLOOR_TWOS 10'sh381
`define START_FLOOR_OFF64 10'sh3C0
`define OFF64_BIAS 10'sh040
`define HYST_DEG 10'sh004
`define LONG_STEP 10'sh001
`define DUTY_SHIFT 3
`define DUTY_MAX 8'hFF

// monitoring cycle counts
`define SHORT_BASE 12'h008
`define SLOW_DIV_LAST 2'h3

// ramp steps in pwm time slots
`define RAMP_0 8'h01
`define RAMP_1 8'h02
`define RAMP_2 8'h03
`define RAMP_3 8'h05
`define RAMP_4 8'h08
`define RAMP_5 8'h0C
`define RAMP_6 8'h18
`define RAMP_7 8'h30

`endif

//--- fan_ctrl_pkg.sv
// Purpose: state types of the dynamic fan threshold controller
// Assumes: constants come from fan_ctrl_consts.svh
// Notes: each design module keeps all of its state in one of these structs
`include "fan_ctrl_consts.svh"
package fan_ctrl_pkg;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [`NCH-1:0][7:0] oppt;
    logic [`NCH-1:0][7:0] lim_lo;
    logic [`NCH-1:0][7:0] lim_hi;
    logic [`NCH-1:0][7:0] start_temp;
    logic [`NCH-1:0][7:0] prev_temp;
    logic [`NCH-1:0][11:0] cyc_cnt;
    logic [`NCH-1:0] slow;
    logic [7:0] acou1;
    logic [7:0] acou2;
    logic off64;
    logic alert_s1;
    logic alert_s2;
    logic alert_s3;
    logic upd;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctrl_state_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [1:0] slow_cnt;
  } smooth_state_t;

endpackage

//--- duty_smoother.sv
// Purpose: per-output pwm duty smoothing for acoustic enhancement
// Assumes: update is a one-cycle pulse per new computed duty
// Notes: slow mode skips three of every four updates in both directions
`include "fan_ctrl_consts.svh"
module duty_smoother
  import fan_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic update,
  input wire logic accel_en,
  input wire logic [2:0] rate_code,
  input wire logic slow,
  input wire logic [7:0] target,
  output logic [7:0] duty
);

  smooth_state_t s;
  smooth_state_t next_s;

  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    logic [7:0] r;
    r = `RAMP_0;
    case (code)
      3'h0: r = `RAMP_0;
      3'h1: r = `RAMP_1;
      3'h2: r = `RAMP_2;
      3'h3: r = `RAMP_3;
      3'h4: r = `RAMP_4;
      3'h5: r = `RAMP_5;
      3'h6: r = `RAMP_6;
      3'h7: r = `RAMP_7;
      default: r = `RAMP_0;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [8:0] up;
    logic [7:0] st;
    up = 9'h000;
    st = ramp_step(rate_code);
    next_s = s;
    if (update) begin
      if (!accel_en) begin
        next_s.duty = target;
        next_s.slow_cnt = 2'h0;
      end else if (slow && s.slow_cnt != `SLOW_DIV_LAST) begin
        next_s.slow_cnt = s.slow_cnt + 2'h1;
      end else begin
        next_s.slow_cnt = 2'h0;
        // only the output duty is smoothed; temperatures pass untouched
        if (target > s.duty) begin
          up = {1'b0, s.duty} + {1'b0, st};
          next_s.duty = (up > {1'b0, target}) ? target : up[7:0];
        end else if (target < s.duty) begin
          next_s.duty = (s.duty - target < st) ? target : s.duty - st;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign duty = s.duty;

endmodule // duty_smoother

//--- dynamic_fan_threshold_ctrl.sv
// Purpose: dynamic fan-start threshold, operating point capture, acoustic smoothing
// Assumes: temperatures and temp_update are synchronous to pclk; apb slave, zero wait
// Notes: channel 0 remote1, 1 local, 2 remote2; pwm n+1 follows channel n
`include "fan_ctrl_consts.svh"
module dynamic_fan_threshold_ctrl
  import fan_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_local,
  input wire logic [7:0] temp_remote2,
  input wire logic temp_update,
  input wire logic thermal_alert_n,
  output logic [7:0] pwm_duty1,
  output logic [7:0] pwm_duty2,
  output logic [7:0] pwm_duty3
);

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [`NCH-1:0][7:0] cur;
  logic [`NCH-1:0][7:0] duty;
  logic [`NCH-1:0][7:0] target;
  logic [`NCH-1:0][2:0] rate;
  logic [`NCH-1:0] accel;

  assign cur = {temp_remote2, temp_local, temp_remote1};

  function automatic logic signed [9:0] to_val(input logic [7:0] raw, input logic off64);
    logic signed [9:0] v;
    v = $signed({{2{raw[7]}}, raw});
    if (off64) begin
      v = $signed({2'b00, raw}) - `OFF64_BIAS;
    end
    return v;
  endfunction

  function automatic logic [7:0] to_raw(input logic signed [9:0] v, input logic off64);
    logic signed [9:0] w;
    w = off64 ? v + `OFF64_BIAS : v;
    return w[7:0];
  endfunction

  function automatic logic [7:0] duty_of(input logic [7:0] t, input logic [7:0] th, input logic off64);
    logic signed [9:0] d;
    logic [12:0] p;
    d = to_val(t, off64) - to_val(th, off64);
    p = {3'b000, d} << `DUTY_SHIFT;
    if (d <= 10'sh000) begin
      return 8'h00;
    end
    return (p > {5'h00, `DUTY_MAX}) ? `DUTY_MAX : p[7:0];
  endfunction

  function automatic logic [2:0] cycle_code(input logic [7:0] c1, input logic [7:0] c2, input int ch);
    logic [2:0] k;
    k = c2[`C2_R1_CODE_LSB +: 3];
    if (ch == 1) begin
      k = c2[`C2_LOC_CODE_LSB +: 3];
    end else if (ch == 2) begin
      k = {c2[`C2_R2_CODE_LSB +: 2], c1[`C1_R2_CODE_LSB]};
    end
    return k;
  endfunction

  always_comb begin
    logic [7:0] idx;
    logic hit;
    logic [7:0] rd;
    logic wen;
    logic alert_edge;
    logic [11:0] n_len;
    logic [11:0] cnt1;
    logic short_cyc;
    logic long_cyc;
    logic signed [9:0] t;
    logic signed [9:0] th;
    logic signed [9:0] op;
    logic signed [9:0] lo;
    logic signed [9:0] hi;
    logic signed [9:0] prv;
    logic signed [9:0] adj;
    logic signed [9:0] floor_v;
    idx = paddr[`PADDR_W-1:2];
    hit = 1'b0;
    rd = 8'h00;
    wen = psel && penable && pwrite && s.pready;
    alert_edge = s.alert_s3 && !s.alert_s2;
    n_len = 12'h000;
    cnt1 = 12'h000;
    short_cyc = 1'b0;
    long_cyc = 1'b0;
    t = 10'sh000;
    th = 10'sh000;
    op = 10'sh000;
    lo = 10'sh000;
    hi = 10'sh000;
    prv = 10'sh000;
    adj = 10'sh000;
    floor_v = s.off64 ? `START_FLOOR_OFF64 : `START_FLOOR_TWOS;
    next_s = s;
    // first stage feeds only the second; edge logic looks at later stages
    next_s.alert_s1 = thermal_alert_n;
    next_s.alert_s2 = s.alert_s1;
    next_s.alert_s3 = s.alert_s2;
    next_s.upd = temp_update;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    for (int ch = 0; ch < `NCH; ch++) begin
      if (temp_update) begin
        t = to_val(cur[ch], s.off64);
        th = to_val(s.start_temp[ch], s.off64);
        op = to_val(s.oppt[ch], s.off64);
        lo = to_val(s.lim_lo[ch], s.off64);
        hi = to_val(s.lim_hi[ch], s.off64);
        prv = to_val(s.prev_temp[ch], s.off64);
        n_len = `SHORT_BASE << cycle_code(s.ctrl1, s.ctrl2, ch);
        cnt1 = s.cyc_cnt[ch] + 12'h001;
        short_cyc = (cnt1 == n_len) || (cnt1 == (n_len << 1));
        long_cyc = (cnt1 == (n_len << 1));
        next_s.cyc_cnt[ch] = long_cyc ? 12'h000 : cnt1;
        next_s.prev_temp[ch] = cur[ch];
        // a temperature under the threshold freezes the adjustment loop
        if (s.ctrl1[`C1_DYN_LSB + ch] && t >= th) begin
          adj = th;
          if (short_cyc && t > op - `HYST_DEG && t > prv) begin
            adj = adj - ((t - prv) <<< 1);
          end
          if (long_cyc && t > op) begin
            adj = adj - `LONG_STEP;
          end
          if (long_cyc && t < lo && t > th && th < hi && th < op) begin
            adj = adj + `LONG_STEP;
          end
          if (adj < floor_v) begin
            adj = floor_v;
          end
          if (adj > hi && adj > th) begin
            adj = (th > hi) ? th : hi;
          end
          next_s.start_temp[ch] = to_raw(adj, s.off64);
        end
      end
    end

    // apb decode, shared by the setup-phase read and the access-phase write
    for (int ch = 0; ch < `NCH; ch++) begin
      if (idx == `IDX_DUTY_BASE + 8'(ch)) begin
        hit = 1'b1;
        rd = duty[ch];
      end
      if (idx == `IDX_OPPT_BASE + 8'(ch)) begin
        hit = 1'b1;
        rd = s.oppt[ch];
        if (wen) next_s.oppt[ch] = pwdata[7:0];
      end
      if (idx == `IDX_LIMIT_BASE + 8'(2 * ch)) begin
        hit = 1'b1;
        rd = s.lim_lo[ch];
        if (wen) next_s.lim_lo[ch] = pwdata[7:0];
      end
      if (idx == `IDX_LIMIT_BASE + 8'(2 * ch + 1)) begin
        hit = 1'b1;
        rd = s.lim_hi[ch];
        if (wen) next_s.lim_hi[ch] = pwdata[7:0];
      end
      if (idx == `IDX_PWMCFG_BASE + 8'(ch)) begin
        hit = 1'b1;
        rd = 8'(s.slow[ch]) << `PWMCFG_SLOW_BIT;
        if (wen) next_s.slow[ch] = pwdata[`PWMCFG_SLOW_BIT];
      end
      if (idx == `IDX_START_BASE + 8'(ch)) begin
        hit = 1'b1;
        rd = s.start_temp[ch];
        if (wen) next_s.start_temp[ch] = pwdata[7:0];
      end
    end
    if (idx == `IDX_CTRL1) begin
      hit = 1'b1;
      rd = s.ctrl1;
      if (wen) next_s.ctrl1 = pwdata[7:0];
    end
    if (idx == `IDX_CTRL2) begin
      hit = 1'b1;
      rd = s.ctrl2;
      if (wen) next_s.ctrl2 = pwdata[7:0];
    end
    if (idx == `IDX_ACOU1) begin
      hit = 1'b1;
      rd = s.acou1;
      if (wen) next_s.acou1 = pwdata[7:0];
    end
    if (idx == `IDX_ACOU2) begin
      hit = 1'b1;
      rd = s.acou2;
      if (wen) next_s.acou2 = pwdata[7:0];
    end
    if (idx == `IDX_CONFIG) begin
      hit = 1'b1;
      rd = 8'(s.off64) << `CONFIG_OFF64_BIT;
      if (wen) next_s.off64 = pwdata[`CONFIG_OFF64_BIT];
    end
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !hit;
      next_s.prdata = {24'h000000, rd};
    end

    // capture after the bus write, so a same-cycle alert wins
    for (int ch = 0; ch < `NCH; ch++) begin
      if (alert_edge && s.ctrl1[`C1_CAP_LSB + ch]) begin
        next_s.oppt[ch] = cur[ch];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl1 <= `RST_CTRL;
      s.ctrl2 <= `RST_CTRL;
      s.oppt <= {`NCH{`RST_OPPT}};
      s.lim_lo <= {`NCH{`RST_LIMIT_LO}};
      s.lim_hi <= {`NCH{`RST_LIMIT_HI}};
      s.start_temp <= {`NCH{`RST_START}};
      s.acou1 <= `RST_ACOU;
      s.acou2 <= `RST_ACOU;
      s.alert_s1 <= 1'b1;
      s.alert_s2 <= 1'b1;
      s.alert_s3 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign accel = {s.acou2[`AC2_EN3_BIT], s.acou2[`AC2_EN2_BIT], s.acou1[`AC1_EN1_BIT]};
  assign rate = {s.acou2[`AC2_RATE3_LSB +: 3], s.acou2[`AC2_RATE2_LSB +: 3], s.acou1[`AC1_RATE1_LSB +: 3]};

  // each output smooths on its own, from the temperature of its own channel
  for (genvar g = 0; g < `NCH; g++) begin : g_pwm
    assign target[g] = duty_of(s.prev_temp[g], s.start_temp[g], s.off64);
    duty_smoother i_duty_smoother (
      .pclk(pclk),
      .presetn(presetn),
      .update(s.upd),
      .accel_en(accel[g]),
      .rate_code(rate[g]),
      .slow(s.slow[g]),
      .target(target[g]),
      .duty(duty[g])
    );
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pwm_duty1 = duty[0];
  assign pwm_duty2 = duty[1];
  assign pwm_duty3 = duty[2];

endmodule // dynamic_fan_threshold_ctrl

//--- fan_ctrl_sva.sv
// Purpose: port-level checks of the fan threshold controller
// Assumes: apb slave answers in one access cycle; duty moves two edges after temp_update
// Notes: thresholds are internal, so checks stay on bus handshake and duty timing
`include "fan_ctrl_consts.svh"
module fan_ctrl_sva
  import fan_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_local,
  input wire logic [7:0] temp_remote2,
  input wire logic temp_update,
  input wire logic thermal_alert_n,
  input wire logic [7:0] pwm_duty1,
  input wire logic [7:0] pwm_duty2,
  input wire logic [7:0] pwm_duty3
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  // index zero is unmapped, so it must be refused with zero data
  a_err_unmapped: assert property (psel && !penable && paddr[9:2] == 8'h00 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_duty1_cause: assert property ($changed(pwm_duty1) |-> $past(temp_update, 2)) else $error("duty1 moved");
  a_duty2_cause: assert property ($changed(pwm_duty2) |-> $past(temp_update, 2)) else $error("duty2 moved");
  a_duty3_cause: assert property ($changed(pwm_duty3) |-> $past(temp_update, 2)) else $error("duty3 moved");
endmodule // fan_ctrl_sva
bind dynamic_fan_threshold_ctrl fan_ctrl_sva i_fan_ctrl_sva(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .temp_remote1, .temp_local, .temp_remote2, .temp_update,
  .thermal_alert_n, .pwm_duty1, .pwm_duty2, .pwm_duty3);

//--- cpu_hot_model.sv
// Purpose: processor throttle output pulling the thermal alert line low
// Assumes: open-drain line with a pull-up, so a released line reads high
// Notes: answers one edge after hot changes, never glitches mid-cycle
module cpu_hot_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hot,
  output logic thermal_alert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_alert_n <= 1'b1;
    end else begin
      thermal_alert_n <= !hot;
    end
  end
endmodule // cpu_hot_model

//--- dynamic_fan_threshold_ctrl_bench.sv
// Purpose: self-checking bench for the fan threshold controller
// Assumes: zero-wait apb slave; channel n drives pwm n+1
// Notes: each scenario starts from a fresh reset so state never leaks between them
`include "fan_ctrl_consts.svh"
module dynamic_fan_threshold_ctrl_bench import fan_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, temp_update = 0, hot = 0;
  logic [`PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, thermal_alert_n;
  logic [7:0] temp_remote1 = 0, temp_local = 0, temp_remote2 = 0, pwm_duty1, pwm_duty2, pwm_duty3;
  int n_errors = 0, check_count = 0;
  always #2.5 pclk = ~pclk;
  dynamic_fan_threshold_ctrl i_dynamic_fan_threshold_ctrl(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .temp_remote1, .temp_local, .temp_remote2, .temp_update,
    .thermal_alert_n, .pwm_duty1, .pwm_duty2, .pwm_duty3);
  cpu_hot_model i_cpu_hot_model(.pclk, .presetn, .hot, .thermal_alert_n);
  task summarize;
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // values read before the edge's updates land, i.e. as sampled at that edge
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    // no cycle count is assumed; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    bus(1'b1, idx, d, q, e);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    bus(1'b0, idx, 8'h00, q, e);
    chk(q, exp);
  endtask
  task rst;
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
  endtask
  // pulses stay four cycles apart, above the two-cycle minimum
  task upd(input int n);
    repeat (n) begin
      @(posedge pclk);
      temp_update <= 1;
      @(posedge pclk);
      temp_update <= 0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task alert;
    hot <= 1;
    repeat (6) @(posedge pclk);
    hot <= 0;
    repeat (6) @(posedge pclk);
  endtask
  task t_regs;
    logic [7:0] q;
    logic e;
    rst();
    rd(`IDX_CTRL1, `RST_CTRL);
    for (int c = 0; c < 3; c++) begin
      rd(`IDX_OPPT_BASE + 8'(c), `RST_OPPT);
      rd(`IDX_START_BASE + 8'(c), `RST_START);
      rd(`IDX_LIMIT_BASE + 8'(2 * c + 1), `RST_LIMIT_HI);
    end
    bus(1'b1, 8'h00, 8'hA5, q, e);
    chk({7'h0, e}, 8'h01);
    wr(`IDX_CTRL1, 8'hE0);
    rd(`IDX_CTRL1, 8'hE0);
  endtask
  task t_capture;
    rst();
    temp_remote1 <= 8'h30;
    temp_local <= 8'h31;
    temp_remote2 <= 8'h32;
    wr(`IDX_CTRL1, 8'h14);
    alert();
    rd(`IDX_OPPT_BASE, 8'h30);
    rd(`IDX_OPPT_BASE + 8'h1, `RST_OPPT);
    rd(`IDX_OPPT_BASE + 8'h2, 8'h32);
    temp_remote1 <= 8'h40;
    temp_local <= 8'h41;
    temp_remote2 <= 8'h42;
    wr(`IDX_CTRL1, 8'h08);
    alert();
    rd(`IDX_OPPT_BASE, 8'h30);
    rd(`IDX_OPPT_BASE + 8'h1, 8'h41);
    rd(`IDX_OPPT_BASE + 8'h2, 8'h32);
  endtask
  task t_limits;
    rst();
    temp_remote1 <= 8'h21;
    wr(`IDX_LIMIT_BASE, 8'h7F);
    wr(`IDX_LIMIT_BASE + 8'h1, 8'h20);
    wr(`IDX_OPPT_BASE, 8'h7E);
    wr(`IDX_START_BASE, 8'h1F);
    wr(`IDX_CTRL1, 8'h20);
    upd(40);
    rd(`IDX_START_BASE, 8'h20);
    chk(pwm_duty1, 8'h08);
    temp_remote1 <= 8'h85;
    wr(`IDX_OPPT_BASE, 8'h81);
    wr(`IDX_START_BASE, 8'h82);
    upd(40);
    rd(`IDX_START_BASE, 8'h81);
    chk(pwm_duty1, 8'h20);
  endtask
  task t_dyn;
    logic [7:0] d;
    for (int c = 0; c < 3; c++) begin
      rst();
      temp_remote1 <= 8'h60;
      temp_local <= 8'h60;
      temp_remote2 <= 8'h60;
      wr(`IDX_OPPT_BASE + 8'(c), 8'h10);
      wr(`IDX_START_BASE + 8'(c), 8'h50);
      upd(32);
      rd(`IDX_START_BASE + 8'(c), 8'h50);
      wr(`IDX_CTRL1, 8'h20 << c);
      upd(32);
      rd(`IDX_START_BASE + 8'(c), 8'h4E);
      d = (c == 0) ? pwm_duty1 : (c == 1) ? pwm_duty2 : pwm_duty3;
      chk(d, 8'h90);
      temp_remote1 <= 8'h40;
      temp_local <= 8'h40;
      temp_remote2 <= 8'h40;
      upd(32);
      rd(`IDX_START_BASE + 8'(c), 8'h4E);
      d = (c == 0) ? pwm_duty1 : (c == 1) ? pwm_duty2 : pwm_duty3;
      chk(d, 8'h00);
    end
  endtask
  task t_acou;
    int ex;
    int ex3;
    int k;
    rst();
    temp_remote1 <= 8'h30;
    temp_local <= 8'h30;
    temp_remote2 <= 8'h30;
    wr(`IDX_START_BASE, 8'h20);
    wr(`IDX_START_BASE + 8'h1, 8'h20);
    wr(`IDX_START_BASE + 8'h2, 8'h20);
    wr(`IDX_ACOU1, 8'h0C);
    // pwm3 ramps by the largest step but only on every fourth update
    wr(`IDX_ACOU2, 8'h0F);
    wr(`IDX_PWMCFG_BASE + 8'h2, 8'h08);
    ex = 0;
    ex3 = 0;
    k = 0;
    repeat (18) begin
      upd(1);
      k++;
      ex = (ex + 8 > 128) ? 128 : ex + 8;
      if (k % 4 == 0) ex3 = (ex3 + 48 > 128) ? 128 : ex3 + 48;
      chk(pwm_duty1, 8'(ex));
      chk(pwm_duty2, 8'h80);
      chk(pwm_duty3, 8'(ex3));
    end
    temp_remote1 <= 8'h20;
    temp_local <= 8'h20;
    temp_remote2 <= 8'h20;
    repeat (4) begin
      upd(1);
      k++;
      ex = ex - 8;
      if (k % 4 == 0) ex3 = (ex3 < 48) ? 0 : ex3 - 48;
      chk(pwm_duty1, 8'(ex));
      chk(pwm_duty2, 8'h00);
      chk(pwm_duty3, 8'(ex3));
    end
  endtask
  task t_modes;
    rst();
    // offset-64 encoding: raw 0x00 is the -64 floor, raw 0x04 is -60
    temp_remote1 <= 8'h04;
    wr(`IDX_CONFIG, 8'h01);
    wr(`IDX_CTRL2, 8'h01);
    wr(`IDX_OPPT_BASE, 8'h00);
    wr(`IDX_START_BASE, 8'h01);
    wr(`IDX_CTRL1, 8'h20);
    upd(16);
    rd(`IDX_START_BASE, 8'h01);
    upd(48);
    rd(`IDX_START_BASE, 8'h00);
    chk(pwm_duty1, 8'h20);
  endtask
  initial begin
    t_regs();
    t_capture();
    t_limits();
    t_dyn();
    t_acou();
    t_modes();
    summarize();
  end
  // the whole run needs about 2000 cycles; allow a wide margin
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule // dynamic_fan_threshold_ctrl_bench
